// ===== pkg/ecw_regs.svh
// Constants of the expansion bus cycle engine
// Assumes a 100 MHz core clock and a bus clock sampled as a plain input
`ifndef ECW_REGS_SVH
`define ECW_REGS_SVH

`define ECW_CLK_PERIOD_NS 10
`define ECW_WAIT_MAX_NS 2500
`define ECW_WAIT_MAX_CYC (`ECW_WAIT_MAX_NS / `ECW_CLK_PERIOD_NS)
`define ECW_CNT_W 9
`define ECW_ADDR_W 32
`define ECW_DATA_W 32

`endif

// ===== pkg/ecw_pkg.sv
// Types of the expansion bus cycle engine
// Assumes ecw_regs.svh is on the include path
`include "ecw_regs.svh"
`default_nettype none

package ecw_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_START,
        ST_CMD,
        ST_END
    } ecw_state_t;

    typedef struct packed {
        logic [`ECW_ADDR_W-1:0] addr;
        logic [`ECW_DATA_W-1:0] wdata;
        logic wr;
        logic io;
        logic mode16;
    } ecw_req_t;

    typedef struct packed {
        logic done;
        logic [`ECW_DATA_W-1:0] rdata;
        logic native;
        logic timeout;
    } ecw_rsp_t;

endpackage

`default_nettype wire

// ===== core/ecw_wait_guard.sv
// Wait-state guard: counts core cycles while a command is stretched
// Assumes i_run is a synchronous level from the cycle engine
`include "ecw_regs.svh"
`default_nettype none

module ecw_wait_guard (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_run,
    output logic o_expired
);

    typedef struct packed {
        logic [`ECW_CNT_W-1:0] cnt;
        logic expired;
    } ecw_guard_t;

    localparam logic [`ECW_CNT_W-1:0] LIMIT = `ECW_CNT_W'(`ECW_WAIT_MAX_CYC);

    ecw_guard_t g_r;
    ecw_guard_t g_nxt;

    // ----------------------------------------
    // Count while running
    // ----------------------------------------
    always_comb begin
        g_nxt = g_r;
        g_nxt.expired = 1'b0;
        if (!i_run) begin
            g_nxt.cnt = '0;
        end else if (g_r.cnt == LIMIT) begin
            g_nxt.expired = 1'b1;
            g_nxt.cnt = '0;
        end else begin
            g_nxt.cnt = g_r.cnt + `ECW_CNT_W'(1);
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            g_r <= '0;
        end else begin
            g_r <= g_nxt;
        end
    end

    assign o_expired = g_r.expired;

endmodule

`default_nettype wire

// ===== core/ecw_master.sv
// Bus master cycle engine for a 32-bit expansion bus
// Assumes bus clock and bus inputs are synchronous to i_clk
`include "ecw_regs.svh"
`default_nettype none

// Notes on behaviour
// - A 32-bit acknowledged memory access completes in two bus clocks.
// - Master samples the 32-bit acknowledge at the trailing edge of start.
// - A 16-bit acknowledged memory access runs in two bus clocks.
// - A 16-bit master flags its width and watches the 16-bit acknowledge.
// - A board may assert the check line to report a serious fault.
// - Write data is placed on the bus before the write strobe asserts.
module ecw_master (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_bclk,
    input wire logic i_exrdy,
    input wire logic i_ex32_n,
    input wire logic i_ex16_n,
    input wire logic [`ECW_DATA_W-1:0] i_data,
    input wire logic i_req_valid,
    input wire ecw_pkg::ecw_req_t i_req,
    input wire logic i_fault,
    input wire logic i_fault_clr,
    output logic o_req_ready,
    output ecw_pkg::ecw_rsp_t o_rsp,
    output logic o_start_n,
    output logic o_cmd_n,
    output logic o_iorc_n,
    output logic o_iowc_n,
    output logic o_master16_n,
    output logic [`ECW_ADDR_W-1:0] o_addr,
    output logic o_wr,
    output logic o_mio,
    output logic [`ECW_DATA_W-1:0] o_data,
    output logic o_data_oe_n,
    output logic o_iochk_o,
    output logic o_iochk_oe_n
);

    typedef struct packed {
        ecw_pkg::ecw_state_t st;
        logic bclk_q;
        logic rdy_seen;
        logic native;
        logic mode16;
        logic req_ready;
        ecw_pkg::ecw_rsp_t rsp;
        logic start_n;
        logic cmd_n;
        logic iorc_n;
        logic iowc_n;
        logic master16_n;
        logic [`ECW_ADDR_W-1:0] addr;
        logic wr;
        logic mio;
        logic [`ECW_DATA_W-1:0] data;
        logic data_oe_n;
        logic fault;
    } ecw_state_r_t;

    ecw_state_r_t s_r;
    ecw_state_r_t s_nxt;
    logic wait_expired;
    logic bclk_rise;
    logic bclk_fall;
    logic ack_now;

    // ----------------------------------------
    // Wait-state guard
    // ----------------------------------------
    // wait time bound
    ecw_wait_guard u_guard (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_run(s_r.st == ecw_pkg::ST_CMD),
        .o_expired(wait_expired)
    );

    // ----------------------------------------
    // Bus clock edges and acknowledge
    // ----------------------------------------
    assign bclk_rise = i_bclk && !s_r.bclk_q;
    assign bclk_fall = !i_bclk && s_r.bclk_q;
    assign ack_now = s_r.mode16 ? !i_ex16_n : !i_ex32_n;

    // ----------------------------------------
    // Cycle sequencer
    // ----------------------------------------
    always_comb begin
        s_nxt = s_r;
        s_nxt.bclk_q = i_bclk;
        s_nxt.rsp.done = 1'b0;
        s_nxt.req_ready = 1'b0;
        if (i_fault) begin
            s_nxt.fault = 1'b1;
        end else if (i_fault_clr) begin
            s_nxt.fault = 1'b0;
        end
        case (s_r.st)
            ecw_pkg::ST_IDLE: begin
                s_nxt.req_ready = 1'b1;
                if (i_req_valid && s_r.req_ready) begin
                    s_nxt.req_ready = 1'b0;
                    s_nxt.addr = i_req.addr;
                    s_nxt.wr = i_req.wr;
                    s_nxt.mio = !i_req.io;
                    s_nxt.mode16 = i_req.mode16;
                    s_nxt.master16_n = !i_req.mode16;
                    s_nxt.data = i_req.wdata;
                    s_nxt.data_oe_n = !i_req.wr;
                    s_nxt.rsp.timeout = 1'b0;
                    s_nxt.st = ecw_pkg::ST_ADDR;
                end
            end
            ecw_pkg::ST_ADDR: begin
                if (bclk_rise) begin
                    s_nxt.start_n = 1'b0;
                    s_nxt.st = ecw_pkg::ST_START;
                end
            end
            ecw_pkg::ST_START: begin
                if (bclk_rise) begin
                    s_nxt.start_n = 1'b1;
                    s_nxt.cmd_n = 1'b0;
                    s_nxt.rdy_seen = 1'b0;
                    s_nxt.native = ack_now;
                    s_nxt.rsp.native = ack_now;
                    s_nxt.iorc_n = !(!s_r.mio && !s_r.wr);
                    s_nxt.iowc_n = !(!s_r.mio && s_r.wr);
                    s_nxt.st = ecw_pkg::ST_CMD;
                end
            end
            ecw_pkg::ST_CMD: begin
                if (bclk_fall && i_exrdy && (s_r.native || ack_now)) begin
                    s_nxt.rdy_seen = 1'b1;
                end
                if (bclk_rise && s_r.rdy_seen) begin
                    s_nxt.cmd_n = 1'b1;
                    s_nxt.iorc_n = 1'b1;
                    s_nxt.iowc_n = 1'b1;
                    s_nxt.rsp.rdata = s_r.wr ? s_r.rsp.rdata : i_data;
                    s_nxt.st = ecw_pkg::ST_END;
                end else if (wait_expired) begin
                    s_nxt.cmd_n = 1'b1;
                    s_nxt.iorc_n = 1'b1;
                    s_nxt.iowc_n = 1'b1;
                    s_nxt.rsp.timeout = 1'b1;
                    s_nxt.fault = 1'b1;
                    s_nxt.st = ecw_pkg::ST_END;
                end
            end
            ecw_pkg::ST_END: begin
                s_nxt.data_oe_n = 1'b1;
                s_nxt.master16_n = 1'b1;
                s_nxt.rsp.done = 1'b1;
                s_nxt.st = ecw_pkg::ST_IDLE;
            end
            default: begin
                s_nxt.st = ecw_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            s_r <= '0;
            s_r.st <= ecw_pkg::ST_IDLE;
            s_r.start_n <= 1'b1;
            s_r.cmd_n <= 1'b1;
            s_r.iorc_n <= 1'b1;
            s_r.iowc_n <= 1'b1;
            s_r.master16_n <= 1'b1;
            s_r.data_oe_n <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign o_req_ready = s_r.req_ready;
    assign o_rsp = s_r.rsp;
    assign o_start_n = s_r.start_n;
    assign o_cmd_n = s_r.cmd_n;
    assign o_iorc_n = s_r.iorc_n;
    assign o_iowc_n = s_r.iowc_n;
    assign o_master16_n = s_r.master16_n;
    assign o_addr = s_r.addr;
    assign o_wr = s_r.wr;
    assign o_mio = s_r.mio;
    assign o_data = s_r.data;
    assign o_data_oe_n = s_r.data_oe_n;
    assign o_iochk_o = 1'b0;
    assign o_iochk_oe_n = !s_r.fault;

endmodule

`default_nettype wire

// ===== sim/ecw_master_properties.sv
// Port checker for the bus cycle engine
// Assumes it is bound into ecw_master
`default_nettype none
module ecw_master_properties (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_exrdy,
    input wire logic i_ex32_n,
    input wire logic i_ex16_n,
    input wire logic i_fault,
    input wire ecw_pkg::ecw_rsp_t o_rsp,
    input wire logic o_start_n,
    input wire logic o_cmd_n,
    input wire logic o_iorc_n,
    input wire logic o_iowc_n,
    input wire logic o_master16_n,
    input wire logic o_wr,
    input wire logic o_mio,
    input wire logic o_data_oe_n,
    input wire logic o_iochk_o,
    input wire logic o_iochk_oe_n
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    logic nat_r;
    logic [8:0] cnt_r;
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            nat_r <= 1'b0;
            cnt_r <= 9'h000;
        end else begin
            cnt_r <= o_cmd_n ? 9'h000 : cnt_r + 9'h001;
            if ($rose(o_start_n)) nat_r <= o_master16_n ? !$past(i_ex32_n) : !$past(i_ex16_n);
        end
    end
    start_cmd_a: assert property ($fell(o_cmd_n) |-> $rose(o_start_n))
        else $error("command without start end");
    cmd_hold_a: assert property (!o_cmd_n && !i_exrdy && cnt_r < 9'd240 |=> !o_cmd_n)
        else $error("command ended while not ready");
    io_read_a: assert property (!o_iorc_n |-> !o_cmd_n && !o_wr && !o_mio)
        else $error("io read strobe misplaced");
    io_write_a: assert property ($fell(o_iowc_n) |-> !$past(o_data_oe_n) && o_wr)
        else $error("write strobe before data");
    width_flag_a: assert property (!o_cmd_n |-> $stable(o_master16_n))
        else $error("width flag moved in command");
    native_a: assert property (o_rsp.done && !o_rsp.timeout |-> o_rsp.native == nat_r)
        else $error("native flag not from start end");
    chk_set_a: assert property (i_fault |=> !o_iochk_oe_n)
        else $error("check line not pulled");
    chk_od_a: assert property (!o_iochk_oe_n |-> !o_iochk_o)
        else $error("check line driven high");
    chk_cause_a: assert property ($fell(o_iochk_oe_n) |-> $past(i_fault) || o_rsp.timeout)
        else $error("check line pulled without cause");
    wait_limit_a: assert property (!o_cmd_n |-> cnt_r < 9'd270)
        else $error("wait longer than limit");
    cover property (o_rsp.done && o_rsp.native);
    cover property (o_rsp.done && !o_rsp.native);
    cover property (o_rsp.done && o_rsp.timeout);
endmodule
bind ecw_master ecw_master_properties u_props (.*);
`default_nettype wire

// ===== sim/ecw_bus_model.sv
// Far side: bus clock, open-collector ready, width ack, read data
// Assumes the bench resolves ready with a pull-up
`default_nettype none
module ecw_bus_model (
    input wire logic i_clk,
    input wire logic i_start_n,
    input wire logic i_cmd_n,
    input wire logic i_native,
    input wire logic [5:0] i_waits,
    output logic o_bclk,
    output logic o_rdy_low,
    output logic o_ack_n,
    output logic [31:0] o_data
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] ph = 3'h0;
    logic [5:0] wl = 6'h00;
    logic [1:0] dv = 2'h0;
    // waits set in start, one per bclk fall
    always @(posedge i_clk) begin
        ph <= ph + 3'h1;
        if (!i_start_n) wl <= i_waits;
        else if (!i_cmd_n && ph == 3'h0 && wl != 6'h00) wl <= wl - 6'h01;
        dv <= !i_cmd_n ? 2'h3 : (dv != 2'h0 ? dv - 2'h1 : 2'h0);
    end
    assign o_bclk = ph[2];
    assign o_rdy_low = wl != 6'h00;
    assign o_ack_n = !((!i_start_n || !i_cmd_n) && (i_native || (wl == 6'h00 && !i_cmd_n)));
    // data held past strobe, then scrambled
    assign o_data = dv != 2'h0 ? 32'ha5c3_0f96 : 32'h5a3c_f069;
endmodule
`default_nettype wire

// ===== sim/ecw_master_tb.sv
// Bench for the bus cycle engine
// Assumes package, design, checker and bus model compiled first
`default_nettype none
module ecw_master_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_clk = 1'b0, i_rstn = 1'b0, i_req_valid = 1'b0, i_fault = 1'b0, i_fault_clr = 1'b0, native = 1'b1;
    logic i_bclk, i_exrdy, i_ex32_n, i_ex16_n, o_req_ready, o_start_n, o_cmd_n, o_iorc_n, o_iowc_n, rdy_low;
    logic o_master16_n, o_wr, o_mio, o_data_oe_n, o_iochk_o, o_iochk_oe_n, ack_n;
    logic [31:0] i_data, o_addr, o_data;
    logic [5:0] waits = 6'h00;
    ecw_pkg::ecw_req_t i_req = '0;
    ecw_pkg::ecw_rsp_t o_rsp;
    int fails = 0, num_checks = 0, len, str, dok;
    assign i_exrdy = !rdy_low;
    assign i_ex32_n = o_master16_n ? ack_n : 1'b1;
    assign i_ex16_n = o_master16_n ? 1'b1 : ack_n;
    ecw_master DUT (.*);
    ecw_bus_model u_bus (.i_clk(i_clk), .i_start_n(o_start_n), .i_cmd_n(o_cmd_n), .i_native(native),
        .i_waits(waits), .o_bclk(i_bclk), .o_rdy_low(rdy_low), .o_ack_n(ack_n), .o_data(i_data));
    initial forever #5 i_clk = ~i_clk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic go(input logic w, io, m16, nat, input logic [5:0] wt, input string nm);
        native = nat;
        waits = wt;
        i_req = '{32'h0000_0040, 32'h1234_5678, w, io, m16};
        i_req_valid = 1'b1;
        while (o_req_ready !== 1'b1) begin
            @(posedge i_clk);
            #1;
        end
        @(posedge i_clk);
        #1 i_req_valid = 1'b0;
        chk(o_addr, 32'h0000_0040);
        chk(o_data, 32'h1234_5678);
        chk({o_mio, o_master16_n, o_data_oe_n}, {!io, !m16, !w});
        len = 0;
        str = 0;
        dok = 0;
        for (int n = 0; n < 900 && o_rsp.done !== 1'b1; n++) begin
            @(posedge i_clk);
            #1 len += int'(!o_cmd_n);
            str += int'(!(w ? o_iowc_n : o_iorc_n));
            dok += int'(!o_iowc_n && !o_data_oe_n && o_data === 32'h1234_5678);
        end
        chk(o_rsp.done, 1'b1);
        chk(o_rsp.native, nat);
        chk(str, io ? len : 0);
        chk(dok, (io && w) ? len : 0);
        if (wt < 6'h20) begin
            chk(len, 8 * wt + 8);
            chk(o_rsp.timeout, 1'b0);
            if (!w) chk(o_rsp.rdata, 32'ha5c3_0f96);
        end
        $display("test %s ended", nm);
    endtask
    task automatic t_io_read();
        go(1'b0, 1'b1, 1'b0, 1'b1, 6'h00, "io read");
    endtask
    task automatic t_mem_write();
        go(1'b1, 1'b0, 1'b0, 1'b1, 6'h03, "mem write waits");
    endtask
    task automatic t_io_write();
        go(1'b1, 1'b1, 1'b0, 1'b1, 6'h01, "io write");
    endtask
    task automatic t_xlate16();
        go(1'b0, 1'b0, 1'b1, 1'b0, 6'h02, "translate 16");
    endtask
    task automatic t_word16();
        go(1'b0, 1'b0, 1'b1, 1'b1, 6'h00, "native 16");
    endtask
    task automatic t_xlate32();
        go(1'b0, 1'b0, 1'b0, 1'b0, 6'h00, "translate 32");
    endtask
    task automatic t_timeout();
        go(1'b0, 1'b1, 1'b0, 1'b1, 6'h28, "timeout");
        chk(o_rsp.timeout, 1'b1);
        chk(o_iochk_oe_n, 1'b0);
        i_fault = 1'b1;
        i_fault_clr = 1'b1;
        @(posedge i_clk);
        #1 i_fault = 1'b0;
        chk(o_iochk_oe_n, 1'b0);
        @(posedge i_clk);
        #1 i_fault_clr = 1'b0;
        chk(o_iochk_oe_n, 1'b1);
        $display("test check line ended");
    endtask
    task automatic conclude();
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge i_clk);
        #1 i_rstn = 1'b1;
        t_io_read();
        t_mem_write();
        t_io_write();
        t_xlate16();
        t_word16();
        t_xlate32();
        t_timeout();
        conclude();
    end
    initial begin
        #100000;
        fails++;
        conclude();
    end
endmodule
`default_nettype wire
